// file: hdl/local_bus_master.v
// local bus master: turns queued operand requests into bus cycles
// assumes slave inputs synchronous to clk; clk is the processor clock derived from
// the double-rate clock, so one bus state equals one clk period
`timescale 1ns/10ps
`include "local_bus_consts.vh"
module local_bus_master (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [31:0] req_addr,
  input  wire [1:0]  req_size,
  input  wire [1:0]  req_space,
  input  wire        req_write,
  input  wire        req_data_cycle,
  input  wire        req_lock,
  input  wire [31:0] req_wdata,
  input  wire        req_valid,
  output wire        req_ready,
  output reg  [31:0] rsp_rdata,
  output reg         rsp_valid,
  input  wire        hold_req,
  output reg         bus_grant_ack,
  input  wire        ready_n,
  input  wire        next_address_req_n,
  input  wire        narrow_bus_size_n,
  output reg  [29:0] dword_address,
  output reg         dword_address_oe_n,
  output reg  [3:0]  byte_lane_selects_n,
  output reg         byte_lane_selects_oe_n,
  output reg         write_read,
  output reg         data_control,
  output reg         memory_io,
  output reg         lock_n,
  output reg         address_strobe_n,
  output reg         ctrl_oe_n,
  output reg  [31:0] data_bus_out,
  output reg         data_bus_oe_n,
  input  wire [31:0] data_bus_in
);
  ////////////////////////////////////////////////////////////////////////////////
  localparam S_IDLE = 2'h0;
  localparam S_T1   = 2'h1;
  localparam S_T2   = 2'h2;
  localparam S_HOLD = 2'h3;

  // contiguous lane mask for a piece starting at byte offset, clipped at dword end
  function [3:0] lane_mask;
    input [1:0] off;
    input [2:0] len;
    reg   [6:0] wide;
    begin
      wide = 7'h0;
      wide = ({3'h0, 4'hf} >> (3'h4 - len)) << off;
      lane_mask = wide[3:0];
    end
  endfunction

  function [2:0] lane_count;
    input [3:0] m;
    begin
      lane_count = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
    end
  endfunction

  wire [`FIFO_WIDTH-1:0] fifo_out;
  wire        fifo_valid;
  reg         fifo_pop;
  sync_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) i_sync_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   ({req_lock, req_data_cycle, req_write, req_space, req_size,
                 req_wdata, req_addr}),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////////
  reg  [1:0]  state;
  reg  [31:0] cur_addr;
  reg  [2:0]  left;
  reg  [63:0] wbuf;
  reg  [63:0] rbuf;
  reg  [3:0]  cur_mask;

  wire [31:0] f_addr  = fifo_out[`FLD_WDATA-1:0];
  wire [31:0] f_wdata = fifo_out[`FLD_WDATA +: 32];
  wire [1:0]  f_size  = fifo_out[`FLD_SIZE +: 2];
  wire [1:0]  f_space = fifo_out[`FLD_SPACE +: 2];
  wire        f_write = fifo_out[`FLD_WRITE];
  wire        f_dcyc  = fifo_out[`FLD_DCYC];
  wire        f_lock  = fifo_out[`FLD_LOCK];
  wire [2:0]  f_len   = {1'b0, f_size} + 3'h1;

  // space mapping of the address put on the bus
  reg  [31:0] bus_addr;
  always @* begin
    case (f_space)
      `SPACE_IO:    bus_addr = f_addr & `IO_ADDR_MASK;
      `SPACE_COPRO: bus_addr = `COPRO_IO_BASE | {29'h0, f_addr[2:0]};
      default:      bus_addr = f_addr;
    endcase
  end
  // operand rotated onto its lanes; upper half feeds the first piece
  wire [63:0] wide_wdata = {f_wdata, f_wdata} << {bus_addr[1:0], 3'h0};

  // highest-order piece goes first; mask of the last dword touched
  wire [32:0] end_addr = {1'b0, bus_addr} + {30'h0, f_len} - 33'h1;
  wire        split    = (end_addr[31:2] != bus_addr[31:2]);
  wire [3:0]  hi_mask  = lane_mask(2'h0, {1'b0, end_addr[1:0]} + 3'h1);
  wire [3:0]  one_mask = lane_mask(bus_addr[1:0], f_len);
  reg  [3:0]  last_mask;
  reg  [2:0]  last_cnt;
  always @* begin
    last_mask = hi_mask;
    last_cnt  = lane_count(hi_mask);
    if (cur_addr[1:0] != 2'h0) begin
      last_mask = lane_mask(cur_addr[1:0], left);
      last_cnt  = left;
    end
  end

  // read lanes of the current piece, placed by dword, then aligned to the operand
  wire [31:0] lane_data = data_bus_in & {{8{cur_mask[3]}}, {8{cur_mask[2]}},
                                         {8{cur_mask[1]}}, {8{cur_mask[0]}}};
  wire [63:0] piece     = {32'h0, lane_data} <<
                          ((dword_address == cur_addr[31:2]) ? 7'h0 : `HI_DWORD_SHIFT);
  wire [63:0] whole     = (rbuf | piece) >> {cur_addr[1:0], 3'h0};

  always @* begin
    fifo_pop = (state == S_IDLE) & fifo_valid & ~hold_req & ce;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst) begin
      state                  <= S_IDLE;
      bus_grant_ack          <= 1'b0;
      address_strobe_n       <= 1'b1;
      byte_lane_selects_n    <= `LANES_RESET;
      dword_address          <= `ADDR_RESET;
      write_read             <= 1'b0;
      data_control           <= 1'b1;
      memory_io              <= 1'b0;
      lock_n                 <= 1'b1;
      data_bus_out           <= `DATA_ZERO;
      data_bus_oe_n          <= 1'b1;
      dword_address_oe_n     <= 1'b0;
      byte_lane_selects_oe_n <= 1'b0;
      ctrl_oe_n              <= 1'b0;
      rsp_rdata              <= `DATA_ZERO;
      rsp_valid              <= 1'b0;
      cur_addr               <= `DATA_ZERO;
      left                   <= 3'h0;
      wbuf                   <= 64'h0;
      rbuf                   <= 64'h0;
      cur_mask               <= `LANES_NONE;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          address_strobe_n <= 1'b1;
          data_bus_oe_n    <= 1'b1;
          if (hold_req) begin
            state                  <= S_HOLD;
            bus_grant_ack          <= 1'b1;
            dword_address_oe_n     <= 1'b1;
            byte_lane_selects_oe_n <= 1'b1;
            ctrl_oe_n              <= 1'b1;
          end else if (fifo_valid) begin
            state            <= S_T1;
            address_strobe_n <= 1'b0;
            write_read       <= f_write;
            data_control     <= f_dcyc;
            memory_io        <= (f_space == `SPACE_MEM);
            lock_n           <= ~f_lock;
            wbuf             <= wide_wdata;
            rbuf             <= 64'h0;
            cur_addr         <= bus_addr;
            if (split) begin
              dword_address       <= end_addr[31:2];
              byte_lane_selects_n <= ~hi_mask;
              cur_mask            <= hi_mask;
              left                <= f_len - lane_count(hi_mask);
            end else begin
              dword_address       <= bus_addr[31:2];
              byte_lane_selects_n <= ~one_mask;
              cur_mask            <= one_mask;
              left                <= 3'h0;
            end
            data_bus_out  <= wide_wdata[63:32];
            data_bus_oe_n <= ~f_write;
          end
        end
        S_T1: begin
          address_strobe_n <= 1'b1;
          state            <= S_T2;
        end
        S_T2: begin
          if (!ready_n) begin
            rbuf <= rbuf | piece;
            if (left != 3'h0) begin
              state               <= S_T1;
              address_strobe_n    <= 1'b0;
              dword_address       <= cur_addr[31:2];
              byte_lane_selects_n <= ~last_mask;
              cur_mask            <= last_mask;
              left                <= left - last_cnt;
              data_bus_out        <= wbuf[31:0];
            end else begin
              state         <= S_IDLE;
              data_bus_oe_n <= 1'b1;
              lock_n        <= 1'b1;
              rsp_valid     <= ~write_read;
              rsp_rdata     <= whole[31:0];
            end
          end
        end
        S_HOLD: begin
          if (!hold_req) begin
            state                  <= S_IDLE;
            bus_grant_ack          <= 1'b0;
            dword_address_oe_n     <= 1'b0;
            byte_lane_selects_oe_n <= 1'b0;
            ctrl_oe_n              <= 1'b0;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // local_bus_master

// file: hdl/local_bus_consts.vh
// constants for the local bus master: pin levels, lane codes, address spaces, timing
// assumes inclusion by local_bus_master.v and sync_fifo.v
`ifndef LOCAL_BUS_CONSTS_VH
`define LOCAL_BUS_CONSTS_VH
`define LANES_NONE      4'hf
`define LANES_RESET     4'h0
`define ADDR_RESET      30'h3fffffff
`define DATA_ZERO       32'h00000000
`define IO_ADDR_MASK    32'h0000ffff
`define COPRO_IO_BASE   32'h800000f8
`define MIN_STATES      2'h2
`define OP_BYTE         2'h0
`define OP_WORD         2'h1
`define OP_DWORD        2'h3
`define SPACE_MEM       2'h0
`define SPACE_IO        2'h1
`define SPACE_COPRO     2'h2
`define FIFO_WIDTH      71
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define FLD_WDATA       32
`define FLD_SIZE        64
`define FLD_SPACE       66
`define FLD_WRITE       68
`define FLD_DCYC        69
`define FLD_LOCK        70
`define HI_DWORD_SHIFT  7'h20
`endif

// file: hdl/sync_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable
`timescale 1ns/10ps
`include "local_bus_consts.vh"
module sync_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sync_fifo

// file: verif/local_bus_master_chk.sv
// checker for local_bus_master bus pin behaviour
// assumes bind from the bench top file, one clock, sync active-high reset
`timescale 1ns/10ps
module local_bus_master_chk (
  input wire        clk,
  input wire        rst,
  input wire        rsp_valid,
  input wire        hold_req,
  input wire        bus_grant_ack,
  input wire        ready_n,
  input wire [29:0] dword_address,
  input wire        dword_address_oe_n,
  input wire [3:0]  byte_lane_selects_n,
  input wire        byte_lane_selects_oe_n,
  input wire        write_read,
  input wire        memory_io,
  input wire        address_strobe_n,
  input wire        ctrl_oe_n,
  input wire        data_bus_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_idle;
    disable iff (1'b0) rst |=> address_strobe_n && byte_lane_selects_n == 4'h0
      && data_bus_oe_n && !bus_grant_ack;
  endproperty
  property p_lane_used; !address_strobe_n |-> byte_lane_selects_n != 4'hf; endproperty
  property p_lane_contig;
    !address_strobe_n |-> ~byte_lane_selects_n inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7,
      4'h8, 4'hc, 4'he, 4'hf};
  endproperty
  property p_addr_stable;
    !address_strobe_n |=> $stable(dword_address) && $stable(byte_lane_selects_n);
  endproperty
  property p_two_states; !address_strobe_n |=> address_strobe_n; endproperty
  property p_rsp_ready; rsp_valid |-> $past(ready_n) == 1'b0; endproperty
  property p_io_space;
    !address_strobe_n && !memory_io |-> dword_address[29:14] == 16'h0000
      || dword_address[29:1] == 29'h1000001f;
  endproperty
  property p_hold_float;
    bus_grant_ack |-> dword_address_oe_n && byte_lane_selects_oe_n && ctrl_oe_n && data_bus_oe_n;
  endproperty
  property p_grant_cause; bus_grant_ack |-> $past(hold_req); endproperty
  property p_read_float; !write_read |-> data_bus_oe_n; endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("bus not idle after reset");
  a_lane_used: assert property (p_lane_used)
    else $error("cycle without lane");
  a_lane_contig: assert property (p_lane_contig)
    else $error("lane pattern not contiguous");
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved in cycle");
  a_two_states: assert property (p_two_states)
    else $error("cycle shorter than two states");
  a_rsp_ready: assert property (p_rsp_ready)
    else $error("read done without ready");
  a_io_space: assert property (p_io_space)
    else $error("io address out of range");
  a_hold_float: assert property (p_hold_float)
    else $error("pins driven while granted");
  a_grant_cause: assert property (p_grant_cause)
    else $error("grant without hold");
  a_read_float: assert property (p_read_float)
    else $error("data driven on read");
  c_read: cover property (rsp_valid);
  c_grant: cover property (bus_grant_ack);
  c_split: cover property (!address_strobe_n ##[1:3] !address_strobe_n);
endmodule // local_bus_master_chk

// file: verif/bus_slave_model.sv
// slave model: answers every cycle after a set number of wait states
// assumes strobe low for one state per cycle; read data is a fixed function of address
`timescale 1ns/10ps
module bus_slave_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [1:0]  waits,
  input  wire        address_strobe_n,
  input  wire [29:0] dword_address,
  output reg         ready_n,
  output reg  [31:0] data_bus_in
);
  reg  [3:0] cnt;
  reg        act;
  function [7:0] bv(input [31:0] x);
    bv = x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  wire [31:0] rd_val = {bv({dword_address, 2'h3}), bv({dword_address, 2'h2}),
                        bv({dword_address, 2'h1}), bv({dword_address, 2'h0})};
  wire [3:0]  nxt = address_strobe_n ? cnt - 4'h1 : {2'h0, waits};
  wire        go = !address_strobe_n || (act && cnt != 4'h0);
  initial data_bus_in = 32'h00000000;
  always @(posedge clk) begin
    if (rst || !go) begin
      act <= 1'b0;
      ready_n <= 1'b1;
      data_bus_in <= ~data_bus_in;
    end else begin
      act <= 1'b1;
      cnt <= nxt;
      ready_n <= nxt != 4'h0;
      data_bus_in <= (nxt == 4'h0) ? rd_val : ~data_bus_in;
    end
  end
endmodule // bus_slave_model

// file: verif/tb_local_bus_master.sv
// bench for local_bus_master: random operands, hold, fifo fill
// assumes the design under hdl/ and the slave model
`timescale 1ns/10ps
module tb_local_bus_master;
  reg clk = 0, rst = 1, req_write = 0, req_valid = 0, hold_req = 1;
  reg req_data_cycle = 1, req_lock = 0;
  reg [31:0] req_addr = 0, req_wdata = 0, a, wd, bm;
  reg [37:0] seen;
  reg [72:0] e;
  reg [1:0]  req_size = 0, req_space = 0, waits = 0, s, sp;
  wire [31:0] rsp_rdata, data_bus_out, slv_data, bus;
  wire [29:0] dword_address;
  wire [3:0]  byte_lane_selects_n;
  wire req_ready, rsp_valid, bus_grant_ack, ready_n, data_bus_oe_n, write_read;
  wire memory_io, address_strobe_n, data_control, lock_n;
  integer seed = 15, bad_count = 0, comparisons = 0, i, n, r;
  reg ok;
  reg [72:0] cyc_q[$];
  reg [31:0] rd_q[$];
  assign bus = data_bus_oe_n ? slv_data : data_bus_out;
  always #50 clk = ~clk;
  local_bus_master i_local_bus_master (.clk(clk), .rst(rst), .ce(1'b1), .req_addr(req_addr),
    .req_size(req_size), .req_space(req_space), .req_write(req_write),
    .req_data_cycle(req_data_cycle), .req_lock(req_lock), .req_wdata(req_wdata),
    .req_valid(req_valid), .req_ready(req_ready),
    .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .hold_req(hold_req),
    .bus_grant_ack(bus_grant_ack), .ready_n(ready_n), .next_address_req_n(1'b1),
    .narrow_bus_size_n(1'b1), .dword_address(dword_address), .dword_address_oe_n(),
    .byte_lane_selects_n(byte_lane_selects_n), .byte_lane_selects_oe_n(),
    .write_read(write_read), .data_control(data_control), .memory_io(memory_io),
    .lock_n(lock_n),
    .address_strobe_n(address_strobe_n), .ctrl_oe_n(), .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n), .data_bus_in(bus));
  bus_slave_model i_bus_slave_model (.clk(clk), .rst(rst), .waits(waits),
    .address_strobe_n(address_strobe_n), .dword_address(dword_address), .ready_n(ready_n),
    .data_bus_in(slv_data));
  function [7:0] bv(input [31:0] x);
    bv = x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  // outside decode of the two low address bits from the lowest enabled lane
  function [1:0] low_bits(input [3:0] be);
    low_bits = !be[0] ? 2'h0 : !be[1] ? 2'h1 : !be[2] ? 2'h2 : 2'h3;
  endfunction
  task fail(input [8*16-1:0] msg);
    bad_count++;
    $display("mismatch at %0t: %0s", $time, msg);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task note(input [31:0] ra, input [1:0] rs, rsp, input rw, dc, lk, input [31:0] wv);
    reg [31:0] ea, d;
    reg [63:0] w;
    reg [7:0]  m;
    integer k;
    ea = rsp == 2'h1 ? ra & 32'h0000ffff : rsp == 2'h2 ? 32'h800000f8 + ra[2:0] : ra;
    m = ((8'h01 << (rs + 1)) - 8'h01) << ea[1:0];
    w = {wv, wv} << {ea[1:0], 3'h0};
    if (m[7:4] != 4'h0) cyc_q.push_back({rsp == 2'h0, rw, dc, ~lk, ea[31:2] + 30'h1,
                                         ~m[7:4], 2'h0, rsp == 2'h2, w[63:32]});
    cyc_q.push_back({rsp == 2'h0, rw, dc, ~lk, ea[31:2], ~m[3:0], ea[1:0], rsp == 2'h2,
                     w[63:32]});
    d = 32'h00000000;
    for (k = 0; k <= rs; k++) d[8*k+:8] = bv(ea + k);
    if (!rw) rd_q.push_back(d);
  endtask
  task go(input integer lim);
    r = $random(seed);
    s = {r[1], r[1] | r[0]};
    sp = r[3:2] == 2'h3 ? 2'h0 : r[3:2];
    a = $random(seed);
    if (sp == 2'h1) a = a & 32'h00007fff;
    if (sp == 2'h2) a = a & 32'h00000004;
    waits <= r[6:5];
    req_addr <= a; req_size <= s; req_space <= sp; req_write <= r[4];
    req_data_cycle <= r[7];
    req_lock <= r[8];
    wd = $random(seed);
    req_wdata <= wd;
    req_valid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (!req_ready && n < lim) begin @(negedge clk); n++; end
    ok = req_ready;
    @(posedge clk);
    if (ok) note(a, s, sp, r[4], r[7], r[8], wd);
  endtask
  task drain;
    for (n = 0; n < 3000 && (cyc_q.size() || rd_q.size()); n++) @(posedge clk);
    if (cyc_q.size() || rd_q.size()) fail("drain timeout");
    repeat (4) @(posedge clk);
  endtask
  always @(negedge clk) if (!rst) begin
    if (!address_strobe_n) begin
      comparisons++;
      e = cyc_q.size() ? cyc_q.pop_front() : {73{1'bx}};
      seen = {memory_io, write_read, data_control, lock_n, dword_address, byte_lane_selects_n};
      bm = {{8{~byte_lane_selects_n[3]}}, {8{~byte_lane_selects_n[2]}},
            {8{~byte_lane_selects_n[1]}}, {8{~byte_lane_selects_n[0]}}};
      if (seen !== e[72:35]) fail("bus cycle");
      if (low_bits(byte_lane_selects_n) !== e[34:33]) fail("low address");
      if ((dword_address[29] & ~memory_io) !== e[32]) fail("copro select");
      if (write_read && (data_bus_out & bm) !== (e[31:0] & bm)) fail("write data");
    end
    if (rsp_valid) begin
      comparisons++;
      if (rsp_rdata !== (rd_q.size() ? rd_q.pop_front() : 32'hx)) fail("read data");
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    hold_req <= 1'b0;
    @(negedge clk);
    comparisons++;
    if (bus_grant_ack !== 1'b0 || address_strobe_n !== 1'b1 || byte_lane_selects_n !== 4'h0 ||
        dword_address !== 30'h3fffffff || data_control !== 1'b1 ||
        lock_n !== 1'b1) fail("reset state");
    @(posedge clk);
    for (i = 0; i < 60; i++) begin go(500); if (!ok) fail("req timeout"); end
    req_valid <= 1'b0;
    drain;
    hold_req <= 1'b1;
    for (n = 0; n < 60 && !bus_grant_ack; n++) @(posedge clk);
    comparisons++;
    if (bus_grant_ack !== 1'b1) fail("no grant");
    i = 0;
    ok = 1'b1;
    while (ok && i < 20) begin go(3); if (ok) i++; end
    req_valid <= 1'b0;
    comparisons++;
    if (i !== 16) fail("fifo depth");
    hold_req <= 1'b0;
    drain;
    end_sim;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail("run timeout");
    end_sim;
  end
endmodule // tb_local_bus_master
bind local_bus_master local_bus_master_chk i_local_bus_master_chk (.clk(clk), .rst(rst),
  .rsp_valid(rsp_valid), .hold_req(hold_req), .bus_grant_ack(bus_grant_ack),
  .ready_n(ready_n), .dword_address(dword_address), .dword_address_oe_n(dword_address_oe_n),
  .byte_lane_selects_n(byte_lane_selects_n), .byte_lane_selects_oe_n(byte_lane_selects_oe_n),
  .write_read(write_read), .memory_io(memory_io), .address_strobe_n(address_strobe_n),
  .ctrl_oe_n(ctrl_oe_n), .data_bus_oe_n(data_bus_oe_n));
